// [cpm_core.sv]
/*
  cpm_core: programmer-visible state of the 8-bit core behind an ahb-lite
  slave: accumulators, index registers, stack pointer, program counter,
  flags, address formation, opcode pages and the stop sequence.
  assumes a single ahb-lite master doing single word transfers on hclk;
  the interrupt and wake pins are asynchronous to hclk.
*/
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module cpm_core
  import cpm_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt and wake pins
  input  wire logic        irq_req,
  input  wire logic        nonmaskable_irq_pin,
  input  wire logic        stop_wake,
  // core status
  output logic             irq_pending,
  output logic             nmi_pending,
  output logic             core_stopped
);

  // programmer model
  logic [15:0]    acc_d;
  logic [15:0]    first_index_reg;
  logic [15:0]    second_index_reg;
  logic [15:0]    stack_ptr;
  logic [15:0]    prog_ctr;
  logic [7:0]     condition_flags;
  logic           osc_delay_select;
  cpm_info_type   instr_info;
  cpm_state_type  state;

  // bus and decode
  cpm_aphase_type aph;
  logic           wr_go;
  logic           cmd_go;
  logic [31:0]    rd_word;
  cpm_cmd_type    cmd;
  logic [7:0]     op_lo;
  logic [7:0]     op_hi;
  logic [3:0]     arg;
  cpm_alu_type    alu;
  cpm_info_type   next_info;
  logic [15:0]    next_pc;
  logic           branch_taken;
  logic [2:0]     opc_bytes;
  logic [1:0]     page;

  // pin synchronisers and stop sequence
  logic [2:0]     pin_meta;
  logic [2:0]     pin_sync;
  logic           wake_cond;
  logic           dly_start;
  logic           dly_done;

  // the slave never stretches a transfer and never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // two flops per pin; only the second stage is used by logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {stop_wake, nonmaskable_irq_pin, irq_req};
      pin_sync <= pin_meta;
    end
  end

  assign irq_pending  = pin_sync[0] & ~condition_flags[CPM_F_I];
  assign nmi_pending  = pin_sync[1] & ~condition_flags[CPM_F_X];
  assign core_stopped = (state != CPM_RUN);

  // address phase capture; hsize is ignored since only words are mapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph <= '0;
    end else if (hready) begin
      aph.addr  <= haddr[CPM_AW-1:0];
      aph.write <= hwrite;
      aph.valid <= hsel & htrans[1];
    end
  end

  assign wr_go  = aph.valid & aph.write;
  // a halted core refuses commands so the state cannot move under it
  assign cmd_go = wr_go && (aph.addr == CPM_OFS_CMD) && (state == CPM_RUN);

  // read mux; unmapped and write-only offsets read as zero
  always_comb begin
    case (haddr[CPM_AW-1:0])
      CPM_OFS_ACC:    rd_word = {16'h0000, acc_d};
      CPM_OFS_IDX1:   rd_word = {16'h0000, first_index_reg};
      CPM_OFS_IDX2:   rd_word = {16'h0000, second_index_reg};
      CPM_OFS_SP:     rd_word = {16'h0000, stack_ptr};
      CPM_OFS_PC:     rd_word = {16'h0000, prog_ctr};
      CPM_OFS_FLAGS:  rd_word = {24'h000000, condition_flags};
      CPM_OFS_INFO:   rd_word = {10'h000, instr_info};
      CPM_OFS_STATUS: rd_word = {27'h0000000, nmi_pending, irq_pending, state};
      CPM_OFS_CTRL:   rd_word = {31'h00000000, osc_delay_select};
      default:        rd_word = 32'h00000000;
    endcase
  end

  // read data is caught at the address phase edge, so it is ready with zero wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // command word fields
  assign cmd   = cpm_cmd_type'(hwdata[CPM_CMD_LSB +: 4]);
  assign op_lo = hwdata[7:0];
  assign op_hi = hwdata[15:8];
  assign arg   = hwdata[CPM_ARG_LSB +: 4];
  assign page  = cpm_page(hwdata[CPM_PRE_LSB +: 8]);

  // arithmetic unit: result and flags for the accumulator commands
  always_comb begin
    alu = '0;
    case (cmd)
      CPM_CMD_ADD:  alu = cpm_add8(acc_d[15:8], op_lo, 1'b0, 1'b0);
      CPM_CMD_ADC:  alu = cpm_add8(acc_d[15:8], op_lo, condition_flags[CPM_F_C], 1'b0);
      CPM_CMD_ABA:  alu = cpm_add8(acc_d[15:8], acc_d[7:0], 1'b0, 1'b0);
      CPM_CMD_SUB:  alu = cpm_add8(acc_d[15:8], op_lo, 1'b0, 1'b1);
      CPM_CMD_ADDD: alu = cpm_add16(acc_d, {op_hi, op_lo});
      CPM_CMD_AND: begin
        alu.res = {8'h00, acc_d[15:8] & op_lo};
        alu.n   = alu.res[7];
        alu.z   = (alu.res[7:0] == 8'h00);
      end
      CPM_CMD_ASL: begin
        alu.res = {8'h00, acc_d[14:8], 1'b0};
        alu.c   = acc_d[15];
        alu.n   = acc_d[14];
        alu.z   = (alu.res[7:0] == 8'h00);
        alu.v   = acc_d[14] ^ acc_d[15];
      end
      default: alu = '0;
    endcase
  end

  // second index opcodes always carry a prebyte, hence one more byte and cycle
  assign opc_bytes = ((arg[2:0] == CPM_M_IDX2) || (page != 2'h0)) ? 3'h2 : 3'h1;

  // effective address, instruction length and page for the address command
  always_comb begin
    next_info       = '0;
    next_info.page  = (arg[2:0] == CPM_M_IDX2 && page == 2'h0) ? 2'h1 : page;
    next_info.extra = (opc_bytes == 3'h2);
    case (arg[2:0])
      CPM_M_IMM8: begin
        next_info.ea  = prog_ctr + {13'h0000, opc_bytes};
        next_info.len = opc_bytes + 3'h1;
      end
      CPM_M_IMM16: begin
        next_info.ea  = prog_ctr + {13'h0000, opc_bytes};
        next_info.len = opc_bytes + 3'h2;
      end
      CPM_M_DIR: begin
        next_info.ea  = {8'h00, op_lo};
        next_info.len = opc_bytes + 3'h1;
      end
      CPM_M_EXT: begin
        next_info.ea  = {op_hi, op_lo};
        next_info.len = opc_bytes + 3'h2;
      end
      CPM_M_IDX1: begin
        next_info.ea  = first_index_reg + {8'h00, op_lo};
        next_info.len = opc_bytes + 3'h1;
      end
      CPM_M_IDX2: begin
        next_info.ea  = second_index_reg + {8'h00, op_lo};
        next_info.len = opc_bytes + 3'h1;
      end
      default: begin
        next_info.ea  = prog_ctr;
        next_info.len = opc_bytes;
      end
    endcase
  end

  // branch: arg picks a flag and the level it must have
  assign branch_taken = (condition_flags[arg[2:0]] == arg[3]);

  // program counter follow-on for each command
  always_comb begin
    case (cmd)
      CPM_CMD_EA:  next_pc = prog_ctr + {13'h0000, next_info.len};
      CPM_CMD_BRA: next_pc = prog_ctr + 16'h0002
                             + (branch_taken ? {{8{op_lo[7]}}, op_lo} : 16'h0000);
      default:     next_pc = prog_ctr;
    endcase
  end

  // accumulators; the first accumulator is the upper half of the pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_d <= 16'h0000;
    end else if (wr_go && aph.addr == CPM_OFS_ACC) begin
      acc_d <= hwdata[15:0];
    end else if (cmd_go) begin
      case (cmd)
        CPM_CMD_ADD, CPM_CMD_ADC, CPM_CMD_ABA, CPM_CMD_SUB, CPM_CMD_AND, CPM_CMD_ASL:
          acc_d[15:8] <= alu.res[7:0];
        CPM_CMD_ADDD: acc_d <= alu.res;
        default:      acc_d <= acc_d;
      endcase
    end
  end

  // index registers, loaded only by software here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_index_reg  <= 16'h0000;
      second_index_reg <= 16'h0000;
    end else if (wr_go) begin
      if (aph.addr == CPM_OFS_IDX1) begin
        first_index_reg <= hwdata[15:0];
      end
      if (aph.addr == CPM_OFS_IDX2) begin
        second_index_reg <= hwdata[15:0];
      end
    end
  end

  // stack pointer: always the next free byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_ptr <= CPM_SP_RST;
    end else if (wr_go && aph.addr == CPM_OFS_SP) begin
      stack_ptr <= hwdata[15:0];
    end else if (cmd_go && cmd == CPM_CMD_PUSH) begin
      stack_ptr <= stack_ptr - 16'h0001;
    end else if (cmd_go && cmd == CPM_CMD_PULL) begin
      stack_ptr <= stack_ptr + 16'h0001;
    end
  end

  // program counter: next instruction address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_ctr <= CPM_PC_RST;
    end else if (wr_go && aph.addr == CPM_OFS_PC) begin
      prog_ctr <= hwdata[15:0];
    end else if (cmd_go && cmd == CPM_CMD_STOP && condition_flags[CPM_F_S]) begin
      prog_ctr <= prog_ctr + 16'h0001;
    end else if (cmd_go) begin
      prog_ctr <= next_pc;
    end
  end

  // instruction info: address, length, page of the last address command;
  // push and pull report the byte address that the stack access used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_info <= '0;
    end else if (cmd_go) begin
      case (cmd)
        CPM_CMD_EA:   instr_info <= next_info;
        CPM_CMD_PUSH: instr_info.ea <= stack_ptr;
        CPM_CMD_PULL: instr_info.ea <= stack_ptr + 16'h0001;
        default:      instr_info <= instr_info;
      endcase
    end
  end

  // flag register, bit order fixed by the field positions in the package
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      condition_flags <= CPM_FLAGS_RST;
    end else if (wr_go && aph.addr == CPM_OFS_FLAGS) begin
      condition_flags <= cpm_tap(condition_flags, hwdata[7:0]);
    end else if (cmd_go) begin
      case (cmd)
        CPM_CMD_ADD, CPM_CMD_ADC, CPM_CMD_ABA: begin
          condition_flags[CPM_F_H] <= alu.h;
          condition_flags[CPM_F_N] <= alu.n;
          condition_flags[CPM_F_Z] <= alu.z;
          condition_flags[CPM_F_V] <= alu.v;
          condition_flags[CPM_F_C] <= alu.c;
        end
        CPM_CMD_SUB, CPM_CMD_ASL, CPM_CMD_ADDD: begin
          condition_flags[CPM_F_N] <= alu.n;
          condition_flags[CPM_F_Z] <= alu.z;
          condition_flags[CPM_F_V] <= alu.v;
          condition_flags[CPM_F_C] <= alu.c;
        end
        CPM_CMD_AND: begin
          condition_flags[CPM_F_N] <= alu.n;
          condition_flags[CPM_F_Z] <= alu.z;
          condition_flags[CPM_F_V] <= 1'b0;
        end
        CPM_CMD_TAP, CPM_CMD_RTI:
          condition_flags <= cpm_tap(condition_flags, op_lo);
        CPM_CMD_NMIA: begin
          condition_flags[CPM_F_X] <= 1'b1;
          condition_flags[CPM_F_I] <= 1'b1;
        end
        CPM_CMD_SETI: condition_flags[CPM_F_I] <= op_lo[0];
        default:      condition_flags <= condition_flags;
      endcase
    end
  end

  // control register: oscillator delay select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_delay_select <= CPM_DLY_RST;
    end else if (wr_go && aph.addr == CPM_OFS_CTRL) begin
      osc_delay_select <= hwdata[0];
    end
  end

  // an unmasked interrupt, the nonmaskable pin or the wake pin ends stop
  assign wake_cond = pin_sync[2] | pin_sync[1] | irq_pending;
  assign dly_start = (state == CPM_HALT) && wake_cond;

  // stop sequence: halt, then settle the oscillator before running again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CPM_RUN;
    end else begin
      case (state)
        CPM_RUN: begin
          if (cmd_go && cmd == CPM_CMD_STOP && !condition_flags[CPM_F_S]) begin
            state <= CPM_HALT;
          end
        end
        CPM_HALT: begin
          if (wake_cond) begin
            state <= CPM_WAKE;
          end
        end
        CPM_WAKE: begin
          if (dly_done) begin
            state <= CPM_RUN;
          end
        end
        default: state <= CPM_RUN;
      endcase
    end
  end

  // settle counter; length chosen by the delay select bit
  cpm_stop_delay u_delay (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (dly_start),
    .long_sel (osc_delay_select),
    .busy     (),
    .done     (dly_done)
  );

endmodule

// [cpm_pkg.sv]
/*
  cpm_pkg: register offsets, field positions, reset values, command codes,
  carrier types and shared arithmetic for the cpu programmer model.
  assumes one hclk domain and an ahb-lite master doing single word transfers.
*/
package cpm_pkg;

  // register map, byte addresses on the bus
  localparam int         CPM_AW         = 8;
  localparam logic [7:0] CPM_OFS_ACC    = 8'h00;
  localparam logic [7:0] CPM_OFS_IDX1   = 8'h04;
  localparam logic [7:0] CPM_OFS_IDX2   = 8'h08;
  localparam logic [7:0] CPM_OFS_SP     = 8'h0c;
  localparam logic [7:0] CPM_OFS_PC     = 8'h10;
  localparam logic [7:0] CPM_OFS_FLAGS  = 8'h14;
  localparam logic [7:0] CPM_OFS_CMD    = 8'h18;
  localparam logic [7:0] CPM_OFS_INFO   = 8'h1c;
  localparam logic [7:0] CPM_OFS_STATUS = 8'h20;
  localparam logic [7:0] CPM_OFS_CTRL   = 8'h24;

  // command word fields
  localparam int CPM_CMD_LSB = 16;
  localparam int CPM_ARG_LSB = 20;
  localparam int CPM_PRE_LSB = 24;

  // flag bit positions
  localparam int CPM_F_S = 7;
  localparam int CPM_F_X = 6;
  localparam int CPM_F_H = 5;
  localparam int CPM_F_I = 4;
  localparam int CPM_F_N = 3;
  localparam int CPM_F_Z = 2;
  localparam int CPM_F_V = 1;
  localparam int CPM_F_C = 0;

  // reset values
  localparam logic [7:0]  CPM_FLAGS_RST = 8'hd0;
  localparam logic [15:0] CPM_SP_RST    = 16'h0000;
  localparam logic [15:0] CPM_PC_RST    = 16'h0000;
  localparam logic        CPM_DLY_RST   = 1'b1;

  // opcode page prebytes
  localparam logic [7:0] CPM_PRE_P2 = 8'h18;
  localparam logic [7:0] CPM_PRE_P3 = 8'h1a;
  localparam logic [7:0] CPM_PRE_P4 = 8'hcd;

  // stop recovery in clock cycles: 4064 and 4
  localparam logic [11:0] CPM_DLY_LONG  = 12'hfe0;
  localparam logic [11:0] CPM_DLY_SHORT = 12'h004;

  // addressing modes of the address command
  localparam logic [2:0] CPM_M_IMM8  = 3'h0;
  localparam logic [2:0] CPM_M_IMM16 = 3'h1;
  localparam logic [2:0] CPM_M_DIR   = 3'h2;
  localparam logic [2:0] CPM_M_EXT   = 3'h3;
  localparam logic [2:0] CPM_M_IDX1  = 3'h4;
  localparam logic [2:0] CPM_M_IDX2  = 3'h5;

  typedef enum logic [3:0] {
    CPM_CMD_ADD  = 4'h0, CPM_CMD_ADC  = 4'h1, CPM_CMD_ABA  = 4'h2, CPM_CMD_SUB  = 4'h3,
    CPM_CMD_AND  = 4'h4, CPM_CMD_ASL  = 4'h5, CPM_CMD_ADDD = 4'h6, CPM_CMD_PUSH = 4'h7,
    CPM_CMD_PULL = 4'h8, CPM_CMD_EA   = 4'h9, CPM_CMD_BRA  = 4'ha, CPM_CMD_STOP = 4'hb,
    CPM_CMD_TAP  = 4'hc, CPM_CMD_RTI  = 4'hd, CPM_CMD_NMIA = 4'he, CPM_CMD_SETI = 4'hf
  } cpm_cmd_type;

  typedef enum logic [2:0] {
    CPM_RUN = 3'b001, CPM_HALT = 3'b010, CPM_WAKE = 3'b100
  } cpm_state_type;

  typedef struct packed {
    logic [CPM_AW-1:0] addr;
    logic              write;
    logic              valid;
  } cpm_aphase_type;

  typedef struct packed {
    logic [15:0] res;
    logic        h;
    logic        n;
    logic        z;
    logic        v;
    logic        c;
  } cpm_alu_type;

  typedef struct packed {
    logic [1:0]  page;
    logic        extra;
    logic [2:0]  len;
    logic [15:0] ea;
  } cpm_info_type;

  // 8-bit add or subtract with all five arithmetic flags
  function automatic cpm_alu_type cpm_add8(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub);
    logic [7:0]  bb;
    logic        ci;
    logic [8:0]  s;
    logic [4:0]  lo;
    cpm_alu_type r;
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    r.res = {8'h00, s[7:0]};
    r.h   = lo[4];
    r.n   = s[7];
    r.z   = (s[7:0] == 8'h00);
    r.v   = (a[7] == bb[7]) && (s[7] != a[7]);
    r.c   = s[8] ^ sub; // borrow is the inverted carry
    return r;
  endfunction

  // 16-bit add for the paired accumulator; half carry has no meaning here
  function automatic cpm_alu_type cpm_add16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    cpm_alu_type r;
    s = {1'b0, a} + {1'b0, b};
    r.res = s[15:0];
    r.h   = 1'b0;
    r.n   = s[15];
    r.z   = (s[15:0] == 16'h0000);
    r.v   = (a[15] == b[15]) && (s[15] != a[15]);
    r.c   = s[16];
    return r;
  endfunction

  // prebyte to page number minus one; anything else is page 1
  function automatic logic [1:0] cpm_page(input logic [7:0] pre);
    case (pre)
      CPM_PRE_P2: return 2'h1;
      CPM_PRE_P3: return 2'h2;
      CPM_PRE_P4: return 2'h3;
      default:    return 2'h0;
    endcase
  endfunction

  // transfer to flags: the nmi mask may be cleared but never set by software
  function automatic logic [7:0] cpm_tap(input logic [7:0] old, input logic [7:0] nw);
    logic [7:0] r;
    r = nw;
    r[CPM_F_X] = old[CPM_F_X] & nw[CPM_F_X];
    return r;
  endfunction

endpackage

// [cpm_stop_delay.sv]
/*
  cpm_stop_delay: oscillator settle counter run after leaving stop.
  assumes start is a one-cycle pulse from logic on hclk.
*/
`timescale 1ns/10ps
module cpm_stop_delay
  import cpm_pkg::*;
#(
  parameter logic [11:0] LONG_CYCLES  = CPM_DLY_LONG,
  parameter logic [11:0] SHORT_CYCLES = CPM_DLY_SHORT
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic start,
  input  wire logic long_sel,
  // result
  output logic      busy,
  output logic      done
);

  logic [11:0] count;

  // load on start, count down, pulse done on the last cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 12'h000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= (long_sel ? LONG_CYCLES : SHORT_CYCLES) - 12'h001;
        busy  <= 1'b1;
      end else if (busy) begin
        if (count == 12'h000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 12'h001;
        end
      end
    end
  end

endmodule

// [cpm_core_props.sv]
/*
  cpm_props: port checker for cpm_core, bound below.
  assumes hready is tied to hreadyout and a single bus master.
*/
`timescale 1ns/10ps
module cpm_props
  import cpm_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins and status
  input wire logic        irq_req,
  input wire logic        nonmaskable_irq_pin,
  input wire logic        stop_wake,
  input wire logic        irq_pending,
  input wire logic        nmi_pending,
  input wire logic        core_stopped
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // accepted address phases
  logic rd_taken;
  logic cmd_taken;
  assign rd_taken  = hsel && htrans[1] && hready && !hwrite;
  assign cmd_taken = hsel && htrans[1] && hready && hwrite && haddr[7:0] == CPM_OFS_CMD;

  no_wait_a: assert property (hreadyout) else $error("wait state seen");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  rdata_hold_a: assert property (!$past(rd_taken) |-> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property ($past(rd_taken && haddr[7:0] > CPM_OFS_CTRL) |-> hrdata == 0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property ($past(rd_taken) |-> hrdata[31:22] == 10'h000)
    else $error("unused read bits set");
  irq_gate_a: assert property (irq_pending |-> $past(irq_req, 2))
    else $error("irq pending without its pin");
  nmi_gate_a: assert property (nmi_pending |-> $past(nonmaskable_irq_pin, 2))
    else $error("nmi pending without its pin");
  stop_entry_a: assert property ($rose(core_stopped) |-> $past(cmd_taken, 2))
    else $error("stop without a command");
  // two sync stages, the wake step and at least four settle cycles keep the core halted
  stop_delay_a: assert property ($rose(stop_wake) && core_stopped |-> core_stopped[*8])
    else $error("stop recovery too short");

  // main scenarios reached
  cover property ($rose(core_stopped));
  cover property ($fell(core_stopped));
  cover property (irq_pending);
endmodule

bind cpm_core cpm_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
  .nonmaskable_irq_pin(nonmaskable_irq_pin), .stop_wake(stop_wake),
  .irq_pending(irq_pending), .nmi_pending(nmi_pending), .core_stopped(core_stopped));

// [test_cpu_programmer_model.sv]
/*
  test_cpu_programmer_model: bus-driven bench for cpm_core.
  assumes zero wait states are possible but waits on hreadyout anyway.
*/
`timescale 1ns/10ps
module test_cpu_programmer_model;
  import cpm_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        irq_req = 1'b0;
  logic        nmi_pin = 1'b0;
  logic        stop_wake = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        irq_pending;
  logic        nmi_pending;
  logic        core_stopped;
  logic [31:0] rv;
  int          num_errors = 0;
  int          comparisons = 0;
  int          n;

  always #12.5 hclk = ~hclk;

  cpm_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .irq_req(irq_req), .nonmaskable_irq_pin(nmi_pin),
    .stop_wake(stop_wake), .irq_pending(irq_pending), .nmi_pending(nmi_pending),
    .core_stopped(core_stopped));

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one single transfer; read data is taken at the end of the data phase
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task rd(input logic [7:0] a, input string w, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(w, rv, exp);
  endtask

  task cmd(input logic [3:0] c, input logic [3:0] arg, input logic [15:0] op,
           input logic [7:0] pre);
    xfer(1'b1, CPM_OFS_CMD, {pre, arg, c, op});
  endtask

  // flags are compared under a mask: only bits the operation owns
  task alu(input logic [3:0] c, input logic [15:0] acc, input logic [7:0] f,
           input logic [15:0] op, input logic [15:0] ea, input logic [7:0] ef,
           input logic [7:0] m);
    xfer(1'b1, CPM_OFS_ACC, {16'h0, acc});
    xfer(1'b1, CPM_OFS_FLAGS, {24'h0, f});
    cmd(c, 4'h0, op, 8'h00);
    rd(CPM_OFS_ACC, "acc", {16'h0, ea});
    xfer(1'b0, CPM_OFS_FLAGS, 32'h0);
    check("flags", rv & {24'h0, m}, {24'h0, ef});
  endtask

  task ea(input logic [7:0] pre, input logic [2:0] md, input logic [1:0] pg, input logic x,
          input logic [2:0] len, input logic [15:0] e);
    xfer(1'b1, CPM_OFS_PC, 32'h1000);
    cmd(CPM_CMD_EA, {1'b0, md}, 16'h1280, pre);
    rd(CPM_OFS_INFO, "info", {10'h0, pg, x, len, e});
    rd(CPM_OFS_PC, "pc", 32'h1000 + len);
  endtask

  // halt, try a refused command, then count cycles from wake to run
  task stop_run(input logic dly, input int lo);
    xfer(1'b1, CPM_OFS_CTRL, {31'h0, dly});
    cmd(CPM_CMD_STOP, 4'h0, 16'h0, 8'h00);
    rd(CPM_OFS_STATUS, "halt", 32'h2);
    check("stopped", core_stopped, 1'b1);
    cmd(CPM_CMD_ADD, 4'h0, 16'h0001, 8'h00);
    stop_wake <= 1'b1;
    n = 0;
    while (core_stopped === 1'b1 && n < 5000) begin
      @(negedge hclk);
      n++;
    end
    @(posedge hclk);
    stop_wake <= 1'b0;
    check("wake", n >= lo && n <= lo + 8, 1'b1);
    rd(CPM_OFS_ACC, "acc_kept", 32'h0);
  endtask

  // watchdog: the long stop recovery dominates the run
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    test_done;
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    rd(CPM_OFS_FLAGS, "flags_rst", {24'h0, CPM_FLAGS_RST});
    rd(CPM_OFS_CTRL, "ctrl_rst", 32'h1);
    rd(8'h28, "unmapped", 32'h0);
    // nmi masked after reset, opened by transfer, shut again by acknowledge
    nmi_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(CPM_OFS_STATUS, "nmi_masked", 32'h01);
    cmd(CPM_CMD_TAP, 4'h0, 16'h0010, 8'h00);
    rd(CPM_OFS_STATUS, "nmi_open", 32'h11);
    check("nmi_pending", nmi_pending, 1'b1);
    cmd(CPM_CMD_NMIA, 4'h0, 16'h0, 8'h00);
    rd(CPM_OFS_FLAGS, "nmi_ack", 32'h50);
    cmd(CPM_CMD_RTI, 4'h0, 16'h0010, 8'h00);
    rd(CPM_OFS_STATUS, "rti_open", 32'h11);
    xfer(1'b1, CPM_OFS_FLAGS, 32'hff);
    rd(CPM_OFS_FLAGS, "x_no_set", 32'hbf);
    nmi_pin <= 1'b0;
    irq_req <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(CPM_OFS_STATUS, "irq_masked", 32'h01);
    cmd(CPM_CMD_SETI, 4'h0, 16'h0000, 8'h00);
    rd(CPM_OFS_STATUS, "irq_open", 32'h09);
    check("irq_pending", irq_pending, 1'b1);
    irq_req <= 1'b0;
    alu(CPM_CMD_ADD, 16'h0800, 8'h00, 16'h0008, 16'h1000, 8'h20, 8'h2f);
    alu(CPM_CMD_ADD, 16'h7f00, 8'h00, 16'h0001, 16'h8000, 8'h2a, 8'h2f);
    alu(CPM_CMD_ADD, 16'hff00, 8'h00, 16'h0001, 16'h0000, 8'h25, 8'h2f);
    alu(CPM_CMD_ADC, 16'h1000, 8'h01, 16'h000f, 16'h2000, 8'h20, 8'h2f);
    alu(CPM_CMD_ABA, 16'h0909, 8'h00, 16'h0000, 16'h1209, 8'h20, 8'h2f);
    alu(CPM_CMD_SUB, 16'h0000, 8'h00, 16'h0001, 16'hff00, 8'h09, 8'h0f);
    alu(CPM_CMD_AND, 16'hf000, 8'h02, 16'h000f, 16'h0000, 8'h04, 8'h0e);
    alu(CPM_CMD_ASL, 16'h8100, 8'h00, 16'h0000, 16'h0200, 8'h03, 8'h0f);
    alu(CPM_CMD_ADDD, 16'hffff, 8'h00, 16'h0001, 16'h0000, 8'h05, 8'h0f);
    xfer(1'b1, CPM_OFS_SP, 32'h0100);
    cmd(CPM_CMD_PUSH, 4'h0, 16'h0, 8'h00);
    rd(CPM_OFS_SP, "push_sp", 32'h00ff);
    rd(CPM_OFS_INFO, "push_ea", 32'h0100);
    cmd(CPM_CMD_PULL, 4'h0, 16'h0, 8'h00);
    rd(CPM_OFS_SP, "pull_sp", 32'h0100);
    rd(CPM_OFS_INFO, "pull_ea", 32'h0100);
    xfer(1'b1, CPM_OFS_IDX1, 32'h2000);
    xfer(1'b1, CPM_OFS_IDX2, 32'h3000);
    ea(8'h00, CPM_M_IMM8, 2'h0, 1'b0, 3'h2, 16'h1001);
    ea(CPM_PRE_P2, CPM_M_IMM16, 2'h1, 1'b1, 3'h4, 16'h1002);
    ea(CPM_PRE_P3, CPM_M_DIR, 2'h2, 1'b1, 3'h3, 16'h0080);
    ea(CPM_PRE_P4, CPM_M_EXT, 2'h3, 1'b1, 3'h4, 16'h1280);
    ea(8'h00, CPM_M_IDX1, 2'h0, 1'b0, 3'h2, 16'h2080);
    ea(8'h00, CPM_M_IDX2, 2'h1, 1'b1, 3'h3, 16'h3080);
    xfer(1'b1, CPM_OFS_FLAGS, 32'h04);
    xfer(1'b1, CPM_OFS_PC, 32'h1000);
    cmd(CPM_CMD_BRA, 4'ha, 16'h00f0, 8'h00);
    rd(CPM_OFS_PC, "bra_taken", 32'h0ff2);
    cmd(CPM_CMD_BRA, 4'h2, 16'h00f0, 8'h00);
    rd(CPM_OFS_PC, "bra_not", 32'h0ff4);
    xfer(1'b1, CPM_OFS_FLAGS, 32'h80);
    cmd(CPM_CMD_STOP, 4'h0, 16'h0, 8'h00);
    rd(CPM_OFS_PC, "stop_nop", 32'h0ff5);
    check("not_stopped", core_stopped, 1'b0);
    xfer(1'b1, CPM_OFS_FLAGS, 32'h10);
    xfer(1'b1, CPM_OFS_ACC, 32'h0);
    stop_run(1'b0, 4);
    stop_run(1'b1, 4064);
    test_done;
  end
endmodule
